// ---- hdl/mfid_regs.sv ----
// memory feature identification register bank, read through the system coprocessor
// assumes requests arrive as single-cycle strobes synchronous to clk from the core
`timescale 1ns/1ps
module mfid_regs
   import mfid_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [3:0]  req_coproc,
   input  wire logic [2:0]  req_opc1,
   input  wire logic [3:0]  req_crn,
   input  wire logic [3:0]  req_crm,
   input  wire logic [2:0]  req_opc2,
   input  wire logic [4:0]  req_mode,
   input  wire logic        req_secure,
   output logic             rsp_valid,
   output logic             rsp_claim,
   output logic             rsp_undef,
   output logic      [31:0] rsp_data
);
   logic        rsp_valid_r;
   logic        rsp_claim_r;
   logic        rsp_undef_r;
   logic [31:0] rsp_data_r;
   logic [31:0] rsp_data_nxt;
   logic        rsp_valid_nxt;
   logic        rsp_claim_nxt;
   logic        rsp_undef_nxt;
   logic [31:0] rom_word;
   wire         base_hit;
   wire         hit_aux;
   wire         hit_mmf0;
   wire         hit_mmf1;
   wire         hit_any;
   wire         priv;
   wire         grant;
   wire         refuse;
   wire [2:0]   sel;
   // per-field views of the returned word, one name per register meaning
   wire [3:0]   fld_reserved;
   wire [3:0]   fld_fast_context_switch_ext;
   wire [3:0]   fld_aux_control;
   wire [3:0]   fld_tightly_coupled_memory;
   wire [3:0]   fld_outer_share;
   wire [3:0]   fld_coherence;
   wire [3:0]   fld_protected_memory_arch;
   wire [3:0]   fld_virtual_memory_arch;
   wire [3:0]   fld_branch_target_buffer;
   wire [3:0]   fld_test_clean;
   wire [3:0]   fld_unified_whole;
   wire [3:0]   fld_split_whole;
   wire [3:0]   fld_unified_set_way;
   wire [3:0]   fld_split_set_way;
   wire [3:0]   fld_unified_by_address;
   wire [3:0]   fld_split_by_address;

   // other selectors in this space belong to neighbouring banks, so no claim
   assign base_hit = req_valid && req_coproc == MFID_COPROC_SYS && req_opc1 == MFID_OPC1
                     && req_crn == MFID_CRN && req_crm == MFID_CRM;
   assign hit_aux  = base_hit && req_opc2 == MFID_OPC2_AUX;
   assign hit_mmf0 = base_hit && req_opc2 == MFID_OPC2_MMF0;
   assign hit_mmf1 = base_hit && req_opc2 == MFID_OPC2_MMF1;
   assign hit_any  = hit_aux || hit_mmf0 || hit_mmf1;
   // req_secure deliberately unused in decode: one copy serves both states
   assign priv     = req_mode != MFID_MODE_USER;
   assign grant    = hit_any && !req_write && priv;
   assign refuse   = hit_any && (req_write || !priv);
   assign sel      = {hit_mmf1, hit_mmf0, hit_aux};

   mfid_rom mfid_rom_inst (
      .sel  (sel),
      .word (rom_word)
   );

   // refused accesses return zero so nothing leaks on the data bus
   assign rsp_data_nxt = grant ? rom_word : MFID_DATA_RESET;
   assign rsp_valid_nxt = grant;
   assign rsp_claim_nxt = hit_any;
   assign rsp_undef_nxt = refuse;

   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid_r <= 1'b0;
         rsp_claim_r <= 1'b0;
         rsp_undef_r <= 1'b0;
         rsp_data_r  <= MFID_DATA_RESET;
      end else if (clk_en) begin
         rsp_valid_r <= rsp_valid_nxt;
         rsp_claim_r <= rsp_claim_nxt;
         rsp_undef_r <= rsp_undef_nxt;
         rsp_data_r  <= rsp_data_nxt;
      end
   end

   assign rsp_valid = rsp_valid_r;
   assign rsp_claim = rsp_claim_r;
   assign rsp_undef = rsp_undef_r;
   assign rsp_data  = rsp_data_r;

   // views only; both registers share nibble positions, so names overlap on purpose
   assign fld_reserved                = rsp_data[MFID_F_RSVD_LSB +: 4];
   assign fld_fast_context_switch_ext = rsp_data[MFID_F_FCTX_LSB +: 4];
   assign fld_aux_control             = rsp_data[MFID_F_AUXCR_LSB +: 4];
   assign fld_tightly_coupled_memory  = rsp_data[MFID_F_TIGHT_LSB +: 4];
   assign fld_outer_share             = rsp_data[MFID_F_OSH_LSB +: 4];
   assign fld_coherence               = rsp_data[MFID_F_COH_LSB +: 4];
   assign fld_protected_memory_arch   = rsp_data[MFID_F_PROT_LSB +: 4];
   assign fld_virtual_memory_arch     = rsp_data[MFID_F_VIRT_LSB +: 4];
   assign fld_branch_target_buffer    = rsp_data[MFID_F_BRBUF_LSB +: 4];
   assign fld_test_clean              = rsp_data[27:24];
   assign fld_unified_whole           = rsp_data[23:20];
   assign fld_split_whole             = rsp_data[19:16];
   assign fld_unified_set_way         = rsp_data[15:12];
   assign fld_split_set_way           = rsp_data[11:8];
   assign fld_unified_by_address      = rsp_data[7:4];
   assign fld_split_by_address        = rsp_data[3:0];

   // checks; req_secure is read only here, one copy must serve both states

   property p_aux_zero;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_aux && grant) |=> (rsp_valid && rsp_data == 32'h0000_0000);
   endproperty
   a_aux_zero: assert property (p_aux_zero) else $error("aux register not zero");

   property p_mmf0_fields;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> (rsp_data[27:24] == 4'h1 && rsp_data[23:20] == 4'h1
         && rsp_data[19:4] == 16'h0000 && rsp_data[3:0] == 4'h3);
   endproperty
   a_mmf0_fields: assert property (p_mmf0_fields) else $error("register zero field wrong");

   property p_mmf0_rsvd;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_reserved == 4'h0;
   endproperty
   a_mmf0_rsvd: assert property (p_mmf0_rsvd) else $error("reserved bits not zero");

   property p_mmf1_fields;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> (rsp_data[31:28] == 4'h2 && rsp_data[27:0] == 28'h0);
   endproperty
   a_mmf1_fields: assert property (p_mmf1_fields) else $error("register one field wrong");

   property p_write_undef;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_any && req_write) |=> (rsp_undef && !rsp_valid && rsp_data == 32'h0);
   endproperty
   a_write_undef: assert property (p_write_undef) else $error("write not refused");

   property p_user_undef;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_any && req_mode == 5'h10) |=> (rsp_undef && !rsp_valid);
   endproperty
   a_user_undef: assert property (p_user_undef) else $error("user read not refused");

   property p_priv_read;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_any && !req_write && req_mode != 5'h10) |=> (rsp_valid && !rsp_undef);
   endproperty
   a_priv_read: assert property (p_priv_read) else $error("privileged read refused");

   property p_secure_same;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> rsp_data == 32'h0110_0003;
   endproperty
   a_secure_same: assert property (p_secure_same) else $error("banked value seen");

   property p_decode_opc2;
      @(posedge clk) disable iff (reset)
      (clk_en && base_hit && req_opc2 == 3'h3) |=> rsp_claim;
   endproperty
   a_decode_opc2: assert property (p_decode_opc2) else $error("selector not claimed");

   property p_no_claim;
      @(posedge clk) disable iff (reset)
      (clk_en && !base_hit) |=> (!rsp_claim && !rsp_valid && !rsp_undef);
   endproperty
   a_no_claim: assert property (p_no_claim) else $error("foreign access claimed");

   property p_freeze;
      @(posedge clk) disable iff (reset)
      !clk_en |=> $stable(rsp_data) && $stable(rsp_valid);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_fast_ctx;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_fast_context_switch_ext == 4'h1;
   endproperty
   a_fast_ctx: assert property (p_fast_ctx) else $error("fast context field wrong");

   property p_aux_control;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_aux_control == 4'h1;
   endproperty
   a_aux_control: assert property (p_aux_control) else $error("aux control field wrong");

   property p_tight_mem;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_tightly_coupled_memory == 4'h0;
   endproperty
   a_tight_mem: assert property (p_tight_mem) else $error("tight memory field wrong");

   property p_outer_share;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_outer_share == 4'h0;
   endproperty
   a_outer_share: assert property (p_outer_share) else $error("shareable field wrong");

   property p_coherence;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_coherence == 4'h0;
   endproperty
   a_coherence: assert property (p_coherence) else $error("coherence field wrong");

   property p_prot_mem;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_protected_memory_arch == 4'h0;
   endproperty
   a_prot_mem: assert property (p_prot_mem) else $error("protected arch field wrong");

   property p_virt_mem;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf0 && grant) |=> fld_virtual_memory_arch == 4'h3;
   endproperty
   a_virt_mem: assert property (p_virt_mem) else $error("virtual arch field wrong");

   property p_branch_buf;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_branch_target_buffer == 4'h2;
   endproperty
   a_branch_buf: assert property (p_branch_buf) else $error("branch buffer field wrong");

   property p_test_clean;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_test_clean == 4'h0;
   endproperty
   a_test_clean: assert property (p_test_clean) else $error("test clean field wrong");

   property p_unified_whole;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_unified_whole == 4'h0;
   endproperty
   a_unified_whole: assert property (p_unified_whole) else $error("unified whole field wrong");

   property p_split_whole;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_split_whole == 4'h0;
   endproperty
   a_split_whole: assert property (p_split_whole) else $error("split whole field wrong");

   property p_unified_set_way;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_unified_set_way == 4'h0;
   endproperty
   a_unified_set_way: assert property (p_unified_set_way) else $error("unified set field wrong");

   property p_split_set_way;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_split_set_way == 4'h0;
   endproperty
   a_split_set_way: assert property (p_split_set_way) else $error("split set field wrong");

   property p_unified_by_address;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_unified_by_address == 4'h0;
   endproperty
   a_unified_by_address: assert property (p_unified_by_address) else $error("unified line wrong");

   property p_split_by_address;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant) |=> fld_split_by_address == 4'h0;
   endproperty
   a_split_by_address: assert property (p_split_by_address) else $error("split line wrong");

   property p_mmf1_secure;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant && req_secure) |=> rsp_data == 32'h2000_0000;
   endproperty
   a_mmf1_secure: assert property (p_mmf1_secure) else $error("secure copy differs");

   property p_mmf1_nonsecure;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_mmf1 && grant && !req_secure) |=> rsp_data == 32'h2000_0000;
   endproperty
   a_mmf1_nonsecure: assert property (p_mmf1_nonsecure) else $error("nonsecure copy differs");

   property p_claim_mmf0;
      @(posedge clk) disable iff (reset)
      (clk_en && base_hit && req_opc2 == 3'h4) |=> rsp_claim;
   endproperty
   a_claim_mmf0: assert property (p_claim_mmf0) else $error("register zero not claimed");

   property p_claim_mmf1;
      @(posedge clk) disable iff (reset)
      (clk_en && base_hit && req_opc2 == 3'h5) |=> rsp_claim;
   endproperty
   a_claim_mmf1: assert property (p_claim_mmf1) else $error("register one not claimed");

   property p_user_no_data;
      @(posedge clk) disable iff (reset)
      (clk_en && hit_any && req_mode == 5'h10) |=> rsp_data == 32'h0000_0000;
   endproperty
   a_user_no_data: assert property (p_user_no_data) else $error("user read leaked data");

   property p_other_opc2;
      @(posedge clk) disable iff (reset)
      (clk_en && base_hit && !hit_any) |=> (!rsp_claim && !rsp_valid && !rsp_undef);
   endproperty
   a_other_opc2: assert property (p_other_opc2) else $error("neighbour selector claimed");

   // guards against two opcode2 codes ever being made equal in the package
   property p_sel_onehot;
      @(posedge clk) disable iff (reset)
      $onehot0(sel);
   endproperty
   a_sel_onehot: assert property (p_sel_onehot) else $error("more than one register hit");
   property p_freeze_flags;
      @(posedge clk) disable iff (reset)
      !clk_en |=> $stable(rsp_claim) && $stable(rsp_undef);
   endproperty
   a_freeze_flags: assert property (p_freeze_flags) else $error("flags moved while frozen");

   property p_reset_clear;
      @(posedge clk)
      reset |=> (!rsp_valid && !rsp_claim && !rsp_undef && rsp_data == 32'h0000_0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left a response");
endmodule

// ---- hdl/mfid_pkg.sv ----
// package for the memory feature identification register bank
// assumes a core pipeline that presents decoded coprocessor register accesses
package mfid_pkg;
   localparam logic [3:0]  MFID_COPROC_SYS   = 4'hF;
   localparam logic [2:0]  MFID_OPC1         = 3'h0;
   localparam logic [3:0]  MFID_CRN          = 4'h0;
   localparam logic [3:0]  MFID_CRM          = 4'h1;
   localparam logic [2:0]  MFID_OPC2_AUX     = 3'h3;
   localparam logic [2:0]  MFID_OPC2_MMF0    = 3'h4;
   localparam logic [2:0]  MFID_OPC2_MMF1    = 3'h5;
   // processor mode field, user mode code
   localparam logic [4:0]  MFID_MODE_USER    = 5'h10;
   // field positions (low bit of each nibble)
   localparam int          MFID_F_RSVD_LSB   = 28;
   localparam int          MFID_F_FCTX_LSB   = 24;
   localparam int          MFID_F_AUXCR_LSB  = 20;
   localparam int          MFID_F_TIGHT_LSB  = 16;
   localparam int          MFID_F_OSH_LSB    = 12;
   localparam int          MFID_F_COH_LSB    = 8;
   localparam int          MFID_F_PROT_LSB   = 4;
   localparam int          MFID_F_VIRT_LSB   = 0;
   localparam int          MFID_F_BRBUF_LSB  = 28;
   localparam logic [31:0] MFID_AUX_VALUE    = 32'h0000_0000;
   localparam logic [31:0] MFID_MMF0_VALUE   = 32'h0110_0003;
   localparam logic [31:0] MFID_MMF1_VALUE   = 32'h2000_0000;
   localparam logic [31:0] MFID_DATA_RESET   = 32'h0000_0000;
   typedef enum logic [2:0] {
      MFID_SEL_AUX  = 3'b001,
      MFID_SEL_MMF0 = 3'b010,
      MFID_SEL_MMF1 = 3'b100
   } mfid_sel_t;
endpackage

// ---- hdl/mfid_rom.sv ----
// constant word lookup for the identification registers
// assumes a one-hot select that is checked by the caller
`timescale 1ns/1ps
module mfid_rom
   import mfid_pkg::*;
(
   input  wire logic [2:0]  sel,
   output logic      [31:0] word
);
   // single copy, no secure/nonsecure banking
   assign word = sel[0] ? MFID_AUX_VALUE :
                 sel[1] ? MFID_MMF0_VALUE :
                 sel[2] ? MFID_MMF1_VALUE : MFID_DATA_RESET;
endmodule

// ---- testbench/mfid_core_model.sv ----
// core pipeline model presenting coprocessor register accesses to the bank
// assumes a free-running clk; every signal changes on the falling edge
`timescale 1ns/1ps
module mfid_core_model (
   input  wire logic       clk,
   output logic            clk_en,
   output logic            req_valid,
   output logic            req_write,
   output logic      [3:0] req_coproc,
   output logic      [2:0] req_opc1,
   output logic      [3:0] req_crn,
   output logic      [3:0] req_crm,
   output logic      [2:0] req_opc2,
   output logic      [4:0] req_mode,
   output logic            req_secure
);
   initial begin
      {req_valid, req_write, req_coproc, req_opc1, req_crn, req_crm} = 17'h0;
      {req_opc2, req_mode, req_secure} = 9'h0;
      clk_en = 1'h1;
   end
   // held until an enabled edge takes it; stalls are random pipeline holds
   task automatic issue(input logic [24:0] f, input logic stall);
      req_valid = 1'h1;
      {req_write, req_coproc, req_opc1, req_crn, req_crm, req_opc2, req_mode, req_secure} = f;
      clk_en = stall ? 1'($urandom) : 1'h1;
      @(posedge clk);
      while (clk_en !== 1'h1) begin
         @(negedge clk);
         clk_en = 1'($urandom);
         @(posedge clk);
      end
      @(negedge clk);
   endtask
   // selector lines are not meaningful while idle, so they are scrambled
   task automatic idle();
      req_valid = 1'h0;
      {req_coproc, req_opc1, req_crn, req_crm} = ~{req_coproc, req_opc1, req_crn, req_crm};
      clk_en = 1'h1;
      @(negedge clk);
   endtask
endmodule

// ---- testbench/mfid_regs_test.sv ----
// self-checking bench for the identification register bank
// assumes the core model drives every request on a falling edge
`timescale 1ns/1ps
module mfid_regs_test;
   import mfid_pkg::*;
   logic        clk, reset, clk_en, req_valid, req_write, req_secure;
   logic        rsp_valid, rsp_claim, rsp_undef;
   logic [3:0]  req_coproc, req_crn, req_crm;
   logic [2:0]  req_opc1, req_opc2;
   logic [4:0]  req_mode;
   logic [31:0] rsp_data;
   logic [35:0] exp_q[$];
   int          errors = 0;
   int          check_count = 0;
   mfid_regs mfid_regs_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
      .req_valid(req_valid), .req_write(req_write), .req_coproc(req_coproc),
      .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2),
      .req_mode(req_mode), .req_secure(req_secure), .rsp_valid(rsp_valid),
      .rsp_claim(rsp_claim), .rsp_undef(rsp_undef), .rsp_data(rsp_data));
   mfid_core_model mfid_core_model_inst (.clk(clk), .clk_en(clk_en),
      .req_valid(req_valid), .req_write(req_write), .req_coproc(req_coproc),
      .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2),
      .req_mode(req_mode), .req_secure(req_secure));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // {hit, valid, claim, undef, data}; f is {write, coproc, opc1, crn, crm, opc2, mode, secure}
   function automatic logic [35:0] expect_rsp(input logic [24:0] f);
      logic [31:0] w;
      logic        hit, bad;
      hit = f[23:9] === {4'hF, 3'h0, 4'h0, 4'h1} && f[8:6] inside {[3'h3:3'h5]};
      w = f[8:6] == 3'h4 ? {4'h0, 4'h1, 4'h1, 4'h0,
                            4'h0, 4'h0, 4'h0, 4'h3}
        : f[8:6] == 3'h5 ? {4'h2, 4'h0, 4'h0, 4'h0,
                            4'h0, 4'h0, 4'h0, 4'h0}
        : 32'h0000_0000;
      bad = f[24] || f[5:1] == 5'h10;
      return {hit, ~bad, 1'h1, bad, bad ? 32'h0000_0000 : w};
   endfunction
   task automatic fail(input string m);
      errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic check_rsp(input logic [34:0] e);
      check_count++;
      if ({rsp_valid, rsp_claim, rsp_undef, rsp_data} !== e)
         fail($sformatf("got %h want %h", {rsp_valid, rsp_claim, rsp_undef, rsp_data}, e));
   endtask
   task automatic req(input logic [24:0] f, input logic stall);
      logic [35:0] e;
      e = expect_rsp(f);
      if (e[35])
         exp_q.push_back(e);
      mfid_core_model_inst.issue(f, stall);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // outputs held by a frozen clk_en are not new results, so skip them
   initial begin
      logic        en_s;
      logic [35:0] e_m;
      forever begin
         @(posedge clk);
         en_s = clk_en & ~reset;
         @(negedge clk);
         if (en_s && (rsp_valid | rsp_claim | rsp_undef) !== 1'h0) begin
            if (exp_q.size() == 0)
               fail("response without a matching request");
            else begin
               e_m = exp_q.pop_front();
               check_rsp(e_m[34:0]);
            end
         end
      end
   end
   initial begin
      #200000;
      fail("watchdog expired");
      tally_and_finish();
   end
   initial begin
      logic [4:0]  modes[8];
      logic [24:0] f;
      modes = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1B, 5'h1F};
      void'($urandom(94));
      reset = 1'h1;
      repeat (20) @(negedge clk);
      reset = 1'h0;
      check_rsp(35'h0);
      // every register, mode, security state and direction, back to back
      for (int o = 3; o <= 5; o++)
         for (int i = 0; i < 32; i++)
            req({i[0], 4'hF, 3'h0, 4'h0, 4'h1, 3'(o), modes[i[4:2]], i[1]}, 1'h0);
      mfid_core_model_inst.idle();
      $display("test sweep done");
      // random accesses, one stray bit may spoil the selector, with stalls
      for (int i = 0; i < 300; i++) begin
         f = {1'($urandom), 4'hF, 3'h0, 4'h0, 4'h1, 3'($urandom), modes[$urandom % 8], 1'($urandom)};
         if ($urandom % 2)
            f ^= 25'h1 << ($urandom % 25);
         req(f, 1'h1);
         if ($urandom % 3 == 0)
            mfid_core_model_inst.idle();
      end
      mfid_core_model_inst.idle();
      mfid_core_model_inst.idle();
      check_count++;
      if (exp_q.size() != 0)
         fail("responses missing");
      $display("test random done");
      tally_and_finish();
   end
endmodule
